/* rtl/timer_pkg.sv */
// Purpose: Shared constants and types for the 16-bit timer/counter
// Assumes: One 40 MHz clock, settings arrive as plain ports
// Notes: Mode and clock-source encodings are local choices
`default_nettype none
package timer_pkg;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 3;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] TOP_RESET = 16'hFFFF;
  localparam logic [11:0] PRESC_RESET = 12'h000;

  typedef enum logic [1:0] {
    MODE_WATCHDOG,
    MODE_CTC,
    MODE_FAST_PWM,
    MODE_PFC_PWM
  } mode_t;

  typedef enum logic [1:0] {
    SRC_CLOCK,
    SRC_CAPTURE_PIN,
    SRC_STOPPED
  } clk_src_t;

  typedef struct packed {
    logic enable;
    mode_t mode;
    clk_src_t clk_src;
    logic [2:0] presc_sel;
    logic [15:0] top;
    logic [15:0] compare;
    logic capture_en;
    logic bus_present;
    logic irq_en_ovf;
    logic irq_en_cmp;
    logic irq_en_cap;
    logic oc_invert;
  } timer_cfg_t;

  typedef struct packed {
    logic ovf;
    logic cmp;
    logic cap;
  } timer_flags_t;
endpackage
`default_nettype wire

/* rtl/timer_prescaler.sv */
// Purpose: Prescaler producing a one-cycle count enable
// Assumes: Source tick is a same-clock qualifier
// Notes: Divide ratio is 2 to the power of the select value
`default_nettype none
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic src_tick,
  input wire logic [2:0] sel,
  // Enable out
  output logic tick
);
  logic [DIV_W-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask = DIV_W'((1 << sel) - 1);
    div_next = div_reg;
    tick_next = 1'b0;
    if (src_tick) begin
      if ((div_reg & mask) == mask) begin
        div_next = '0;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= DIV_W'(PRESC_RESET);
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule
`default_nettype wire

/* rtl/hard_timer_counter.sv */
// Purpose: 16-bit up/down timer with compare, PWM and capture
// Assumes: Settings held stable or driven by fabric logic
// Notes: Flags clear on a one-cycle clear pulse; set wins
//
// Operation
// (R1) A 16-bit counter counting up or down.
// (R2) Modes: watchdog, clear on compare, fast PWM, phase-frequency correct PWM.
// (R3) Selectable count clock source followed by a programmable prescaler.
// (R4) Independent compare unit drives a waveform on the compare output.
// (R5) PWM output glitch free, with adjustable period through top value.
// (R6) Three interrupt causes: overflow, compare match, input capture.
// (R7) One static interrupt output toward user logic.
// (R8) One wake-up interrupt line to the standby controller.
// (R9) Synchronised rising capture edge stores count in capture register, in non-PWM modes with bus present.
// (R10) With bus, irq gated by enables; without, irq shows overflow.
// (R11) Registers reached by fabric master; here exposed as plain ports.
// (R12) Stand-alone operation from preloaded settings, with direct reset input.
// (R13) Reset-pin enable preloaded so the direct reset always acts.
// (R14) Direct reset is active low and holds count, flags, outputs.
`default_nettype none
module hard_timer_counter
  import timer_pkg::*;
#(
  parameter logic RESET_PIN_ENABLE_SETTING = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timer_reset_low,
  // Settings from fabric or preload
  input wire timer_cfg_t cfg, // R11
  input wire logic [2:0] flag_clear,
  // Pins
  input wire logic capture_trigger_in,
  output logic compare_waveform_out,
  output logic timer_irq_out,
  output logic wakeup_irq_out,
  // Status
  output logic [15:0] count_value,
  output logic [15:0] capture_register,
  output timer_flags_t flags,
  output logic count_down
);
  // ===========================================================
  // Reset and input synchronisers
  // ===========================================================
  logic [1:0] rst_sync_reg;
  logic [2:0] cap_sync_reg;
  logic run_rst_n;
  logic cap_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
      cap_sync_reg <= 3'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], timer_reset_low};
      cap_sync_reg <= {cap_sync_reg[1:0], capture_trigger_in};
    end
  end

  assign run_rst_n = rst_sync_reg[1] | ~RESET_PIN_ENABLE_SETTING; // R13
  assign cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2]; // R9

  // ===========================================================
  // Clock source and prescaler
  // ===========================================================
  logic src_tick;
  logic cnt_tick;

  always_comb begin
    case (cfg.clk_src) // R3
      SRC_CLOCK: src_tick = cfg.enable;
      SRC_CAPTURE_PIN: src_tick = cfg.enable & cap_rise;
      SRC_STOPPED: src_tick = 1'b0;
      default: src_tick = 1'b0;
    endcase
  end

  timer_prescaler #(.DIV_W(12)) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .sel(cfg.presc_sel),
    .tick(cnt_tick)
  );

  // ===========================================================
  // Counter, compare and flags
  // ===========================================================
  logic [15:0] cnt_reg, cnt_next;
  logic dir_reg, dir_next;
  logic [15:0] cmp_buf_reg, cmp_buf_next;
  logic [15:0] top_buf_reg, top_buf_next;
  logic [15:0] icr_reg, icr_next;
  logic oc_reg, oc_next;
  timer_flags_t flg_reg, flg_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic ev_ovf, ev_cmp, ev_cap;
  logic pwm_mode;

  assign pwm_mode = (cfg.mode == MODE_FAST_PWM) || (cfg.mode == MODE_PFC_PWM);

  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    cmp_buf_next = cmp_buf_reg;
    top_buf_next = top_buf_reg;
    oc_next = oc_reg;
    ev_ovf = 1'b0;
    ev_cmp = 1'b0;
    ev_cap = 1'b0;
    if (!pwm_mode) begin
      cmp_buf_next = cfg.compare;
      top_buf_next = cfg.top;
    end
    if (cnt_tick) begin
      ev_cmp = (cnt_reg == cmp_buf_reg); // R4
      case (cfg.mode) // R2
        MODE_WATCHDOG: begin
          cnt_next = cnt_reg + 16'h0001; // R1
          ev_ovf = (cnt_reg == TOP_RESET);
        end
        MODE_CTC: begin
          if (cnt_reg == cmp_buf_reg) begin
            cnt_next = CNT_RESET;
            oc_next = ~oc_reg; // R4
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
          ev_ovf = (cnt_reg == TOP_RESET);
        end
        MODE_FAST_PWM: begin
          if (cnt_reg >= top_buf_reg) begin
            cnt_next = CNT_RESET;
            ev_ovf = 1'b1;
            cmp_buf_next = cfg.compare; // R5
            top_buf_next = cfg.top; // R5
            oc_next = (cfg.compare != CNT_RESET);
          end else begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg + 16'h0001 == cmp_buf_reg) begin
              oc_next = 1'b0;
            end
          end
        end
        MODE_PFC_PWM: begin
          if (!dir_reg) begin
            if (cnt_reg >= top_buf_reg) begin
              dir_next = 1'b1; // R1
              cnt_next = cnt_reg - 16'h0001;
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
          end else if (cnt_reg == CNT_RESET) begin
            dir_next = 1'b0;
            cnt_next = cnt_reg + 16'h0001;
            ev_ovf = 1'b1;
            cmp_buf_next = cfg.compare; // R5
            top_buf_next = cfg.top; // R5
          end else begin
            cnt_next = cnt_reg - 16'h0001;
          end
          oc_next = (cnt_next < cmp_buf_next);
        end
        default: cnt_next = cnt_reg;
      endcase
    end
    if (!pwm_mode) begin
      dir_next = 1'b0;
    end
    icr_next = icr_reg;
    if (cfg.capture_en && !pwm_mode && cfg.bus_present && cap_rise) begin
      ev_cap = 1'b1; // R9
      icr_next = cnt_reg;
    end
    flg_next.ovf = ev_ovf | (flg_reg.ovf & ~flag_clear[0]); // R6
    flg_next.cmp = ev_cmp | (flg_reg.cmp & ~flag_clear[1]); // R6
    flg_next.cap = ev_cap | (flg_reg.cap & ~flag_clear[2]); // R6
    if (cfg.bus_present) begin
      irq_next = (flg_next.ovf & cfg.irq_en_ovf) | (flg_next.cmp & cfg.irq_en_cmp)
        | (flg_next.cap & cfg.irq_en_cap); // R10 R7
    end else begin
      irq_next = flg_next.ovf; // R10 R12
    end
    wake_next = irq_next; // R8
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET;
      dir_reg <= 1'b0;
      cmp_buf_reg <= TOP_RESET;
      top_buf_reg <= TOP_RESET;
      icr_reg <= CNT_RESET;
      oc_reg <= 1'b0;
      flg_reg <= '0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (!run_rst_n) begin
      cnt_reg <= CNT_RESET; // R14
      dir_reg <= 1'b0;
      cmp_buf_reg <= TOP_RESET;
      top_buf_reg <= TOP_RESET;
      icr_reg <= CNT_RESET;
      oc_reg <= 1'b0;
      flg_reg <= '0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      cmp_buf_reg <= cmp_buf_next;
      top_buf_reg <= top_buf_next;
      icr_reg <= icr_next;
      oc_reg <= oc_next;
      flg_reg <= flg_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  // ===========================================================
  // Outputs
  // ===========================================================
  logic oc_out_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_out_reg <= 1'b0;
    end else begin
      oc_out_reg <= run_rst_n & (oc_next ^ cfg.oc_invert); // R4
    end
  end

  assign compare_waveform_out = oc_out_reg;
  assign timer_irq_out = irq_reg;
  assign wakeup_irq_out = wake_reg;
  assign count_value = cnt_reg;
  assign capture_register = icr_reg;
  assign flags = flg_reg;
  assign count_down = dir_reg;

  // ===========================================================
  // Checks
  // ===========================================================
  a_reset_holds_count: assert property (@(posedge clk) disable iff (!rst_n) // R14
    !run_rst_n |=> (cnt_reg == CNT_RESET && !irq_reg))
    else $error("count not held in direct reset");
  a_capture_stamps: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (run_rst_n && ev_cap) |=> (icr_reg == $past(cnt_reg)))
    else $error("capture value wrong");
  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (run_rst_n && ev_ovf) |=> flg_reg.ovf)
    else $error("overflow flag lost");
  a_irq_standalone: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (run_rst_n && !cfg.bus_present) |=> (timer_irq_out == $past(flg_next.ovf)))
    else $error("standalone irq not overflow");
  a_wake_follows: assert property (@(posedge clk) disable iff (!rst_n) // R8
    wakeup_irq_out == timer_irq_out)
    else $error("wake line differs");
  a_count_up_watchdog: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (run_rst_n && cnt_tick && cfg.mode == MODE_WATCHDOG)
    |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
    else $error("watchdog count not incremented");
  a_ctc_clears: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (run_rst_n && cnt_tick && cfg.mode == MODE_CTC && cnt_reg == cmp_buf_reg)
    |=> cnt_reg == CNT_RESET)
    else $error("ctc not cleared");
  a_pfc_bounds: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (run_rst_n && cnt_tick && cfg.mode == MODE_PFC_PWM && dir_reg && cnt_reg == 16'h0000)
    |=> !dir_reg ##0 flg_reg.ovf)
    else $error("pfc bottom not turned");
endmodule
`default_nettype wire

/* tb/fabric_model.sv */
// Purpose: Fabric-side model driving the capture pin
// Assumes: fire is a one-cycle request from the bench
// Notes: Pin held high four cycles so the synchroniser sees it
`default_nettype none
module fabric_model (
  // Clock
  input wire logic clk,
  // Request and pin
  input wire logic fire,
  output logic trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_reg = 3'h0;
  always @(posedge clk) begin
    if (fire) begin
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign trigger = (hold_reg != 3'h0);
endmodule
`default_nettype wire

/* tb/hard_timer_counter_bench.sv */
// Purpose: Self-checking bench for the 16-bit timer/counter
// Assumes: Settings driven as plain ports at the rising edge
// Notes: Counts judged over whole periods to stay phase free
`default_nettype none
module hard_timer_counter_bench;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, trl, fire, trig, oc, irq, wake, dn_o;
  timer_cfg_t cfg;
  logic [2:0] flag_clear;
  logic [15:0] cnt, cap, mx, hi;
  timer_flags_t flags;
  logic dn;
  int error_cnt = 0;
  int check_count = 0;

  hard_timer_counter DUT (.clk(clk), .rst_n(rst_n), .timer_reset_low(trl),
    .cfg(cfg), .flag_clear(flag_clear), .capture_trigger_in(trig),
    .compare_waveform_out(oc), .timer_irq_out(irq), .wakeup_irq_out(wake),
    .count_value(cnt), .capture_register(cap), .flags(flags), .count_down(dn_o));
  fabric_model fabric (.clk(clk), .fire(fire), .trigger(trig));

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic setup(input mode_t m, input logic [2:0] s, input logic [15:0] t,
      input logic [15:0] c, input logic b, input logic [2:0] en);
    @(posedge clk);
    cfg <= '{enable: 1'b1, mode: MODE_WATCHDOG, clk_src: SRC_CLOCK, presc_sel: s, top: t,
      compare: c, capture_en: 1'b1, bus_present: b, irq_en_ovf: en[0],
      irq_en_cmp: en[1], irq_en_cap: en[2], oc_invert: 1'b0};
    // Non-PWM cycle loads the compare and top buffers
    @(posedge clk);
    cfg.mode <= m;
  endtask

  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic watch(input int n);
    mx = 16'h0000;
    hi = 16'h0000;
    dn = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (cnt > mx) mx = cnt;
      hi = hi + {15'h0000, oc};
      dn = dn | dn_o;
    end
  endtask

  task automatic clear_flags();
    @(posedge clk);
    flag_clear <= 3'h7;
    @(posedge clk);
    flag_clear <= 3'h0;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_rate();
    logic [15:0] c0;
    for (int s = 0; s < 3; s++) begin
      setup(MODE_WATCHDOG, s[2:0], 16'hFFFF, 16'hFFFF, 1'b0, 3'h0);
      repeat (8) @(negedge clk);
      c0 = cnt;
      repeat (16) @(negedge clk);
      chk("rate", cnt - c0, 16'h0010 >> s);
    end
  endtask

  task automatic t_pwm();
    logic [15:0] tops [2] = '{16'h0009, 16'h0005};
    foreach (tops[i]) begin
      setup(MODE_FAST_PWM, 3'h0, tops[i], 16'h0002, 1'b0, 3'h0);
      watch(30);
      watch(2 * (tops[i] + 1));
      chk("pwm top", mx, tops[i]);
      chk("pwm high", hi, 16'h0004);
    end
    chk("ovf flag", flags.ovf, 1'b1);
    chk("irq ovf", irq, 1'b1);
  endtask

  task automatic t_ctc();
    clear_flags();
    setup(MODE_CTC, 3'h0, 16'hFFFF, 16'h0006, 1'b1, 3'h2);
    watch(20);
    chk("ctc top", mx, 16'h0006);
    chk("cmp flag", flags.cmp, 1'b1);
    chk("irq cmp", irq, 1'b1);
    chk("wake", wake, 1'b1);
    setup(MODE_CTC, 3'h0, 16'hFFFF, 16'h0006, 1'b1, 3'h0);
    clear_flags();
    repeat (3) @(negedge clk);
    chk("irq masked", irq, 1'b0);
    chk("ovf cleared", flags.ovf, 1'b0);
  endtask

  task automatic t_pfc();
    setup(MODE_PFC_PWM, 3'h0, 16'h0005, 16'h0003, 1'b0, 3'h0);
    watch(20);
    watch(20);
    chk("pfc top", mx, 16'h0005);
    chk("pfc down", dn, 1'b1);
    chk("pfc high", hi, 16'h000A);
  endtask

  task automatic t_cap();
    int k;
    clear_flags();
    setup(MODE_CTC, 3'h0, 16'hFFFF, 16'hFFFF, 1'b1, 3'h4);
    repeat (4) @(posedge clk);
    pulse();
    for (k = 0; k < 12 && flags.cap !== 1'b1; k++) @(negedge clk);
    if (k == 12) begin
      error_cnt++;
      complete_run();
    end
    chk("irq cap", irq, 1'b1);
    chk("stamp near", 16'(cnt - cap <= 16'h0005), 16'h0001);
    chk("stamp set", 16'(cap != 16'h0000), 16'h0001);
  endtask

  task automatic t_direct();
    @(posedge clk);
    trl <= 1'b0;
    repeat (4) @(negedge clk);
    chk("held count", cnt, 16'h0000);
    chk("held flags", 16'(flags), 16'h0000);
    chk("held irq", irq, 1'b0);
    chk("held oc", oc, 16'h0000);
    chk("held stamp", cap, 16'h0000);
    @(posedge clk);
    trl <= 1'b1;
    repeat (8) @(negedge clk);
    chk("resumed", 16'(cnt != 16'h0000), 16'h0001);
  endtask

  task automatic t_src();
    logic [15:0] c0;
    logic v;
    setup(MODE_WATCHDOG, 3'h0, 16'hFFFF, 16'hFFFF, 1'b0, 3'h0);
    @(posedge clk);
    cfg.clk_src <= SRC_CAPTURE_PIN;
    repeat (4) @(negedge clk);
    c0 = cnt;
    pulse();
    repeat (10) @(negedge clk);
    chk("pin count", cnt - c0, 16'h0001);
    @(posedge clk);
    cfg.clk_src <= SRC_STOPPED;
    repeat (4) @(negedge clk);
    c0 = cnt;
    v = oc;
    @(posedge clk);
    cfg.oc_invert <= 1'b1;
    repeat (4) @(negedge clk);
    chk("stopped", cnt - c0, 16'h0000);
    chk("invert", oc, {15'h0000, ~v});
  endtask

  // ==========================================
  // Main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    trl = 1'b1;
    fire = 1'b0;
    cfg = '0;
    flag_clear = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset count", cnt, 16'h0000);
    chk("reset irq", irq, 1'b0);
    t_rate();
    t_pwm();
    t_ctc();
    t_pfc();
    t_cap();
    t_direct();
    t_src();
    complete_run();
  end
endmodule
`default_nettype wire
